// file: irq_priority_ctrl.sv
// What this block does
// R1: Sixteen sources, each with one of four levels.
// R2: Hardware sets a flag on its event.
// R3: Request needs global enable, own enable, flag; sources without an IE bit need only global enable and flag.
// R4: Enter only when no higher level active.
// R5: Higher level preempts; lower waits for completion.
// R6: Equal level never preempts an active routine.
// R7: Levels 0 lowest to 3, reset 0.
// R8: Higher level first; ties go smaller index.
// R9: Global enable off forwards no request.
// R10: Pending flag taken once enables turn on.
// R11: Software clears flag before enabling source.
// R12: External channels take rise, fall or both.
// R13: Channel 0: port-0 pin, P1.1 or comparator.
// R14: Channel 1: sixteen pins, own flags, enables.
// R15: Software sets channel enable before pin enables.
// R16: Reset vector 0x0000; sources 0x0003 step 8.
// R17: Fixed source order zero first, fifteen last.
// R18: Channel 1 edge and level from its fields.
// R19: Edge code 00 rise, 01 fall, 1X both.
// R20: Writing zero clears flag, one does nothing; pin flag registers take the written value.
// R21: Two-bit level fields, four per register.
// R22: CPU signals completion to release its level.
// R23: Pins synchronised; each edge sets once.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
module irq_priority_ctrl import irq_ctrl_pkg::*; (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic [P0_PINS-1:0]   port0Pins,
  input  wire logic [PORT_PINS-1:0] port1Pins,
  input  wire logic [PORT_PINS-1:0] port2Pins,
  input  wire logic              cmp4Out,
  input  wire logic [NUM_SRC-1:0] srcFlag,
  input  wire logic              thermalEvent,
  input  wire logic              irqAck,
  input  wire logic              irqDone,
  output logic                   irqReq,
  output logic      [15:0]       irqVector,
  output logic      [3:0]        irqSrc,
  output logic      [1:0]        irqLevel,
  output logic      [NUM_LVL-1:0] activeLevels
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rstPipe;
  logic       rstSyncN;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // ****************************************************************
  // Pin edges
  // ****************************************************************
  edge_if edgeBus ();

  pin_edge_detect u_edges (
    .clk_sys  (clk_sys),
    .rstSyncN (rstSyncN),
    .pinAsync ({cmp4Out, port2Pins, port1Pins, port0Pins}),
    .edges    (edgeBus.det)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]            ie;
    logic [3:0][7:0]       prio;
    logic [1:0]            ext0Edge;
    logic [1:0]            ext1Edge;
    logic                  ext0Flag;
    logic                  thermFlag;
    logic [PORT_PINS-1:0]  p1En;
    logic [PORT_PINS-1:0]  p1Flag;
    logic [PORT_PINS-1:0]  p2En;
    logic [PORT_PINS-1:0]  p2Flag;
    logic [EXT0_CFG_W-1:0] ext0_pin_select;
    logic [NUM_LVL-1:0]    active;
    logic                  req;
    logic [15:0]           vec;
    logic [3:0]            src;
    logic [1:0]            lvl;
    logic [DATA_W-1:0]     rdata;
  } ctrl_s;

  ctrl_s              q;
  ctrl_s              d;
  logic               ext0Rise;
  logic               ext0Fall;
  logic               ext0Ev;
  logic [2:0]         ext0Sel;
  logic [NUM_SRC-1:0] srcReq;
  logic               found;
  logic [3:0]         bestSrc;
  logic [1:0]         bestLvl;
  logic [1:0]         candLvl;

  always_comb begin
    d        = q;
    ext0Rise = 1'b0;
    ext0Fall = 1'b0;
    ext0Sel  = q.ext0_pin_select[EXT0_SEL_LSB +: 3];
    found    = 1'b0;
    bestSrc  = 4'h0;
    bestLvl  = RST_LVL;
    candLvl  = RST_LVL;

    if (regWr) begin
      case (regAddr)
        ADDR_IE:       d.ie = regWdata & IE_MASK;
        ADDR_PRIO0:    d.prio[0] = regWdata; // R21
        ADDR_PRIO1:    d.prio[1] = regWdata; // R21
        ADDR_PRIO2:    d.prio[2] = regWdata; // R21
        ADDR_PRIO3:    d.prio[3] = regWdata; // R21
        ADDR_TRIG: begin
          d.ext0Edge = regWdata[TRIG_EXT0_EDGE +: 2];
          d.ext1Edge = regWdata[TRIG_EXT1_EDGE +: 2]; // R18
          if (!regWdata[TRIG_EXT0_FLAG]) d.ext0Flag = 1'b0; // R20
          if (!regWdata[TRIG_THERM_FLAG]) d.thermFlag = 1'b0; // R20
        end
        ADDR_P1_EN:    d.p1En = regWdata;
        ADDR_P1_FLAG:  d.p1Flag = regWdata;
        ADDR_P2_EN:    d.p2En = regWdata;
        ADDR_P2_FLAG:  d.p2Flag = regWdata;
        ADDR_EXT0_CFG: d.ext0_pin_select = regWdata[EXT0_CFG_W-1:0];
        default: ;
      endcase
    end

    // Edges are muxed after detection, so reselecting the trigger
    // cannot fake an edge.
    if (q.ext0_pin_select[EXT0_ALT]) begin // R13
      ext0Rise = edgeBus.rise[PIN_P1_1];
      ext0Fall = edgeBus.fall[PIN_P1_1];
    end else if (q.ext0_pin_select[EXT0_CMP]) begin // R13
      ext0Rise = edgeBus.rise[PIN_COMPARATOR_FOUR];
      ext0Fall = edgeBus.fall[PIN_COMPARATOR_FOUR];
    end else if (ext0Sel < 3'(P0_PINS)) begin // R13
      ext0Rise = edgeBus.rise[PIN_P0_LSB + ext0Sel];
      ext0Fall = edgeBus.fall[PIN_P0_LSB + ext0Sel];
    end
    ext0Ev = edgeHit(q.ext0Edge, ext0Rise, ext0Fall); // R12 R19

    // Hardware set wins over a software clear in the same cycle.
    d.ext0Flag  = d.ext0Flag | ext0Ev; // R2
    d.thermFlag = d.thermFlag | thermalEvent; // R2
    for (int i = 0; i < PORT_PINS; i++) begin
      d.p1Flag[i] = d.p1Flag[i] | edgeHit(q.ext1Edge, // R14 R18
        edgeBus.rise[PIN_P1_LSB + i], edgeBus.fall[PIN_P1_LSB + i]);
      d.p2Flag[i] = d.p2Flag[i] | edgeHit(q.ext1Edge, // R14 R18
        edgeBus.rise[PIN_P2_LSB + i], edgeBus.fall[PIN_P2_LSB + i]);
    end

    srcReq = srcFlag;
    srcReq[SRC_EXT0]  = d.ext0Flag & d.ie[IE_EXT0]; // R3
    srcReq[SRC_EXT1]  = d.ie[IE_EXT1] & // R14
      (|({d.p2Flag, d.p1Flag} & {d.p2En, d.p1En}));
    srcReq[SRC_RTC]   = srcFlag[SRC_RTC] & d.ie[IE_RTC]; // R3
    srcReq[SRC_THERM] = d.thermFlag & d.ie[IE_THERM]; // R3
    srcReq[SRC_UART]  = srcFlag[SRC_UART] & d.ie[IE_UART]; // R3
    srcReq[SRC_SPI]   = srcFlag[SRC_SPI] & d.ie[IE_SPI]; // R3
    if (!d.ie[IE_GLOBAL]) srcReq = '0; // R9 R10

    // Completion frees the top level before a new entry is recorded.
    if (irqDone && (|q.active)) d.active[topLevel(q.active)] = 1'b0; // R22
    if (irqAck && q.req) d.active[q.lvl] = 1'b1; // R22

    // Arbitration uses next-cycle state so the request never lags.
    for (int i = 0; i < NUM_SRC; i++) begin // R1 R17
      candLvl = srcLevel(d.prio, 4'(i));
      if (srcReq[i] && // R4 R5 R6
          (!(|d.active) || candLvl > topLevel(d.active)) &&
          (!found || candLvl > bestLvl)) begin // R8
        found   = 1'b1;
        bestSrc = 4'(i);
        bestLvl = candLvl;
      end
    end
    d.req = found;
    d.src = bestSrc;
    d.lvl = bestLvl;
    d.vec = found ? vecOf(bestSrc) : VEC_RESET; // R16

    d.rdata = RST_BYTE;
    if (regRd) begin
      case (regAddr)
        ADDR_IE:       d.rdata = q.ie;
        ADDR_PRIO0:    d.rdata = q.prio[0];
        ADDR_PRIO1:    d.rdata = q.prio[1];
        ADDR_PRIO2:    d.rdata = q.prio[2];
        ADDR_PRIO3:    d.rdata = q.prio[3];
        ADDR_TRIG:     d.rdata = {2'b00, q.thermFlag, q.ext1Edge,
                                  q.ext0Flag, q.ext0Edge};
        ADDR_P1_EN:    d.rdata = q.p1En;
        ADDR_P1_FLAG:  d.rdata = q.p1Flag;
        ADDR_P2_EN:    d.rdata = q.p2En;
        ADDR_P2_FLAG:  d.rdata = q.p2Flag;
        ADDR_EXT0_CFG: d.rdata = {3'b000, q.ext0_pin_select};
        default:       d.rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '0; // R7
    end else begin
      q <= d;
    end
  end

  assign regRdata     = q.rdata;
  assign irqReq       = q.req;
  assign irqVector    = q.vec;
  assign irqSrc       = q.src;
  assign irqLevel     = q.lvl;
  assign activeLevels = q.active;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  property p_global_off;
    !q.ie[IE_GLOBAL] |-> !irqReq;
  endproperty
  a_global_off: assert property (p_global_off) // R9
    else $error("request forwarded with global enable off");

  property p_ext0_needs_enables;
    irqReq && irqSrc == SRC_EXT0 |->
      q.ie[IE_EXT0] && q.ext0Flag && q.ie[IE_GLOBAL];
  endproperty
  a_ext0_needs_enables: assert property (p_ext0_needs_enables) // R3
    else $error("channel 0 request without flag or enables");

  property p_vector;
    irqReq |-> irqVector == VEC_BASE + {9'h000, irqSrc, 3'h0};
  endproperty
  a_vector: assert property (p_vector) // R16
    else $error("vector does not match source");

  property p_vec_last;
    irqReq && irqSrc == SRC_DMA |-> irqVector == VEC_LAST;
  endproperty
  a_vec_last: assert property (p_vec_last) // R16
    else $error("last source vector wrong");

  property p_nesting;
    irqReq && (|q.active) |-> irqLevel > topLevel(q.active);
  endproperty
  a_nesting: assert property (p_nesting) // R6
    else $error("request not above active level");

  property p_ack_marks;
    irqAck && irqReq |=> q.active[$past(irqLevel)];
  endproperty
  a_ack_marks: assert property (p_ack_marks) // R22
    else $error("entered level not recorded");

  property p_ext0_clear;
    regWr && regAddr == ADDR_TRIG && !regWdata[TRIG_EXT0_FLAG] &&
      !ext0Ev |=> !q.ext0Flag;
  endproperty
  a_ext0_clear: assert property (p_ext0_clear) // R20
    else $error("zero write did not clear channel 0 flag");

  property p_ext0_one_noeffect;
    regWr && regAddr == ADDR_TRIG && regWdata[TRIG_EXT0_FLAG] &&
      !q.ext0Flag && !ext0Ev |=> !q.ext0Flag;
  endproperty
  a_ext0_one_noeffect: assert property (p_ext0_one_noeffect) // R20
    else $error("one write set channel 0 flag");

  property p_therm_set;
    thermalEvent |=> q.thermFlag;
  endproperty
  a_therm_set: assert property (p_therm_set) // R2
    else $error("thermal event lost");

  c_nested: cover property (irqAck && irqReq && (|q.active));
  c_done: cover property (irqDone && (|q.active));
  c_ext1_pin: cover property (q.req && q.src == SRC_EXT1);

endmodule

// file: irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_SRC   = 16;
  localparam int NUM_LVL   = 4;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 8;
  localparam int PORT_PINS = 8;
  localparam int P0_PINS   = 7;
  localparam int NUM_PINS  = 24;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] IDX_TRIG     = 8'h88;
  localparam logic [7:0] IDX_IE       = 8'ha8;
  localparam logic [7:0] IDX_PRIO0    = 8'hb8;
  localparam logic [7:0] IDX_PRIO1    = 8'hc0;
  localparam logic [7:0] IDX_PRIO2    = 8'hc8;
  localparam logic [7:0] IDX_PRIO3    = 8'hd8;
  localparam logic [7:0] IDX_P1_EN    = 8'hd1;
  localparam logic [7:0] IDX_P1_FLAG  = 8'hd2;
  localparam logic [7:0] IDX_P2_EN    = 8'hd3;
  localparam logic [7:0] IDX_P2_FLAG  = 8'hd4;
  localparam logic [7:0] IDX_EXT0_CFG = 8'he1;

  localparam logic [ADDR_W-1:0] ADDR_TRIG     = {IDX_TRIG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IE       = {IDX_IE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIO0    = {IDX_PRIO0, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIO1    = {IDX_PRIO1, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIO2    = {IDX_PRIO2, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PRIO3    = {IDX_PRIO3, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_P1_EN    = {IDX_P1_EN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_P1_FLAG  = {IDX_P1_FLAG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_P2_EN    = {IDX_P2_EN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_P2_FLAG  = {IDX_P2_FLAG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EXT0_CFG = {IDX_EXT0_CFG, 2'b00};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int IE_GLOBAL = 7;
  localparam int IE_RTC    = 6;
  localparam int IE_UART   = 4;
  localparam int IE_SPI    = 3;
  localparam int IE_EXT1   = 2;
  localparam int IE_THERM  = 1;
  localparam int IE_EXT0   = 0;
  localparam logic [7:0] IE_MASK = 8'hdf;

  localparam int TRIG_THERM_FLAG = 5;
  localparam int TRIG_EXT1_EDGE  = 3;
  localparam int TRIG_EXT0_FLAG  = 2;
  localparam int TRIG_EXT0_EDGE  = 0;

  localparam int EXT0_SEL_LSB = 0;
  localparam int EXT0_ALT     = 3;
  localparam int EXT0_CMP     = 4;
  localparam int EXT0_CFG_W   = 5;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_LVL  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] SETTLE    = 2'h3;

  // ****************************************************************
  // Sources, pins and vectors
  // ****************************************************************
  localparam logic [3:0] SRC_EXT0  = 4'h1;
  localparam logic [3:0] SRC_EXT1  = 4'h2;
  localparam logic [3:0] SRC_RTC   = 4'h8;
  localparam logic [3:0] SRC_THERM = 4'hb;
  localparam logic [3:0] SRC_UART  = 4'hc;
  localparam logic [3:0] SRC_SPI   = 4'he;
  localparam logic [3:0] SRC_DMA   = 4'hf;

  localparam int PIN_P0_LSB = 0;
  localparam int PIN_P1_LSB = 7;
  localparam int PIN_P2_LSB = 15;
  localparam int PIN_P1_1   = 8;
  localparam int PIN_COMPARATOR_FOUR   = 23;

  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam logic [15:0] VEC_LAST  = 16'h007b;

  function automatic logic edgeHit(input logic [1:0] mode,
                                   input logic       rise,
                                   input logic       fall);
    if (mode[1]) return rise | fall;
    if (mode == EDGE_FALL) return fall;
    return rise;
  endfunction

  function automatic logic [15:0] vecOf(input logic [3:0] src);
    return VEC_BASE + {9'h000, src, 3'h0};
  endfunction

  function automatic logic [1:0] srcLevel(input logic [3:0][7:0] prio,
                                          input logic [3:0]      src);
    return prio[src[3:2]][{src[1:0], 1'b0} +: 2];
  endfunction

  function automatic logic [1:0] topLevel(input logic [3:0] act);
    if (act[3]) return 2'h3;
    if (act[2]) return 2'h2;
    if (act[1]) return 2'h1;
    return 2'h0;
  endfunction

endpackage

// file: edge_if.sv
interface edge_if import irq_ctrl_pkg::*; ();
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;
  modport det (output rise, output fall);
  modport use_side (input rise, input fall);
endinterface

// file: pin_edge_detect.sv
module pin_edge_detect import irq_ctrl_pkg::*; (
  input wire logic                clk_sys,
  input wire logic                rstSyncN,
  input wire logic [NUM_PINS-1:0] pinAsync,
  edge_if.det                     edges
);

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
    logic [NUM_PINS-1:0] s3;
    logic [NUM_PINS-1:0] stable;
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] fall;
    logic [1:0]          settle;
  } det_s;

  det_s q;
  det_s d;
  logic [NUM_PINS-1:0] agree;

  // A level counts only once two later stages agree, so a pin caught
  // mid-change cannot make two edges.
  always_comb begin
    d        = q;
    d.s1     = pinAsync;
    d.s2     = q.s1;
    d.s3     = q.s2;
    agree    = ~(q.s2 ^ q.s3);
    d.stable = (agree & q.s3) | (~agree & q.stable); // R23
    d.rise   = '0;
    d.fall   = '0;
    if (q.settle != SETTLE) begin
      // Pins that are already high at reset must not look like edges.
      d.settle = q.settle + 2'h1;
      d.stable = q.s2;
    end else begin
      d.rise = d.stable & ~q.stable; // R23
      d.fall = ~d.stable & q.stable; // R23
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign edges.rise = q.rise;
  assign edges.fall = q.fall;

  property p_edge_once;
    @(posedge clk_sys) disable iff (!rstSyncN)
      (q.rise != '0) |=> ((q.rise & $past(q.rise)) == '0);
  endproperty
  a_edge_once: assert property (p_edge_once) // R23
    else $error("pin edge reported twice in a row");

endmodule

// file: cpu_model.sv
module cpu_model import irq_ctrl_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        irqReq,
  input  wire logic [15:0] irqVector,
  input  wire logic        ackOn,
  input  wire logic [1:0]  ackDelay,
  input  wire logic        retire,
  output logic             irqAck,
  output logic             irqDone,
  output logic      [15:0] lastVector
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] waitQ;

  // ****************************************************************
  // Vector entry and return
  // ****************************************************************
  // A slow core lets a request stand for ackDelay cycles before entry.
  // The ack never repeats back to back, because no ack is given while
  // irqAck is high; the request only drops in the cycle after it is taken.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqAck     <= 1'h0;
      irqDone    <= 1'h0;
      waitQ      <= 2'h0;
      lastVector <= 16'h0000;
    end else begin
      irqDone <= retire;
      irqAck  <= 1'h0;
      if (ackOn && irqReq && !irqAck) begin
        if (waitQ == ackDelay) begin
          irqAck     <= 1'h1;
          lastVector <= irqVector;
          waitQ      <= 2'h0;
        end else begin
          waitQ <= waitQ + 2'h1;
        end
      end else begin
        waitQ <= 2'h0;
      end
    end
  end
endmodule

// file: prioritized_interrupt_controller_test.sv
module prioritized_interrupt_controller_test import irq_ctrl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk_sys = 1'h0;
  logic                 rstn = 1'h0;
  logic                 regWr = 1'h0;
  logic                 regRd = 1'h0;
  logic                 cmp4Out = 1'h0;
  logic                 thermalEvent = 1'h0;
  logic                 ackOn = 1'h0;
  logic                 retire = 1'h0;
  logic [1:0]           ackDelay = 2'h0;
  logic [ADDR_W-1:0]    regAddr = '0;
  logic [DATA_W-1:0]    regWdata = '0;
  logic [DATA_W-1:0]    regRdata;
  logic [P0_PINS-1:0]   port0Pins = '0;
  logic [PORT_PINS-1:0] port1Pins = '0;
  logic [PORT_PINS-1:0] port2Pins = '0;
  logic [NUM_SRC-1:0]   srcFlag = '0;
  logic                 irqAck;
  logic                 irqDone;
  logic                 irqReq;
  logic [15:0]          irqVector;
  logic [15:0]          lastVector;
  logic [15:0]          rdVal;
  logic [3:0]           irqSrc;
  logic [1:0]           irqLevel;
  logic [NUM_LVL-1:0]   activeLevels;
  int                   fails = 0;
  int                   checks = 0;

  irq_priority_ctrl uut (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .port0Pins(port0Pins), .port1Pins(port1Pins), .port2Pins(port2Pins),
    .cmp4Out(cmp4Out), .srcFlag(srcFlag), .thermalEvent(thermalEvent),
    .irqAck(irqAck), .irqDone(irqDone), .irqReq(irqReq),
    .irqVector(irqVector), .irqSrc(irqSrc), .irqLevel(irqLevel),
    .activeLevels(activeLevels));

  cpu_model core (.clk_sys(clk_sys), .rstn(rstn), .irqReq(irqReq),
    .irqVector(irqVector), .ackOn(ackOn), .ackDelay(ackDelay),
    .retire(retire), .irqAck(irqAck), .irqDone(irqDone),
    .lastVector(lastVector));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chkF(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr    <= 1'h1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clk_sys);
    regRd   <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1;
    rdVal = 16'(regRdata);
  endtask

  task automatic setFlags(input logic [NUM_SRC-1:0] v);
    @(posedge clk_sys);
    srcFlag <= v;
    tick(1);
  endtask

  task automatic take();
    int i;
    i = 0;
    @(posedge clk_sys);
    ackOn <= 1'h1;
    do begin
      tick(1);
      i++;
    end while (irqAck !== 1'h1 && i < 8);
    if (irqAck !== 1'h1) begin
      fails++;
      $display("unexpected at %0t: no entry by the core", $time);
      wrap_up();
    end else begin
      @(posedge clk_sys);
      ackOn <= 1'h0;
      #1;
    end
  endtask

  task automatic retireOne();
    @(posedge clk_sys);
    retire <= 1'h1;
    @(posedge clk_sys);
    retire <= 1'h0;
    tick(1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [ADDR_W-1:0] a [11];
    a = '{ADDR_TRIG, ADDR_IE, ADDR_PRIO0, ADDR_PRIO1, ADDR_PRIO2,
          ADDR_PRIO3, ADDR_P2_FLAG, ADDR_P1_EN, ADDR_P1_FLAG,
          ADDR_P2_EN, ADDR_EXT0_CFG};
    foreach (a[i]) begin
      rd(a[i]);
      chk(rdVal, 16'h0000);
    end
    rd(10'h004);
    chk(rdVal, 16'h0000);
    wr(ADDR_PRIO2, 8'he4);
    rd(ADDR_PRIO2);
    chk(rdVal, 16'h00e4);
    wr(ADDR_IE, 8'hff);
    rd(ADDR_IE);
    chk(rdVal, 16'h00df);
    wr(ADDR_IE, 8'h00);
    wr(ADDR_PRIO2, 8'h00);
  endtask

  task automatic t_thermal();
    wr(ADDR_IE, 8'h02);
    @(posedge clk_sys);
    thermalEvent <= 1'h1;
    @(posedge clk_sys);
    thermalEvent <= 1'h0;
    tick(3);
    chkF(irqReq, 1'h0);
    wr(ADDR_IE, 8'h82);
    chkF(irqReq, 1'h1);
    chk(16'(irqSrc), 16'(SRC_THERM));
    chk(irqVector, 16'h005b);
    take();
    chk(16'(activeLevels), 16'h0001);
    chkF(irqReq, 1'h0);
    wr(ADDR_TRIG, 8'h24);
    rd(ADDR_TRIG);
    chk(rdVal, 16'h0020);
    wr(ADDR_TRIG, 8'h00);
    rd(ADDR_TRIG);
    chk(rdVal, 16'h0000);
    retireOne();
    chk(16'(activeLevels), 16'h0000);
  endtask

  task automatic t_arb();
    wr(ADDR_IE, 8'h80);
    wr(ADDR_PRIO3, 8'hc0);
    setFlags(16'h8001);
    chk(16'(irqSrc), 16'h000f);
    chk(irqVector, 16'h007b);
    chk(16'(irqLevel), 16'h0003);
    wr(ADDR_PRIO3, 8'h00);
    chk(irqVector, 16'h0003);
    setFlags(16'h0030);
    chk(16'(irqSrc), 16'h0004);
    ackDelay <= 2'h2;
    setFlags(16'h0008);
    take();
    chk(lastVector, 16'h001b);
    setFlags(16'h0048);
    chkF(irqReq, 1'h0);
    wr(ADDR_PRIO1, 8'h10);
    chk(16'(irqSrc), 16'h0006);
    take();
    chk(16'(activeLevels), 16'h0003);
    setFlags(16'h0080);
    chkF(irqReq, 1'h0);
    retireOne();
    chk(16'(activeLevels), 16'h0001);
    chkF(irqReq, 1'h0);
    retireOne();
    chk(16'(irqSrc), 16'h0007);
    setFlags(16'h0000);
    wr(ADDR_PRIO1, 8'h00);
    ackDelay <= 2'h0;
  endtask

  task automatic t_ext0();
    logic [7:0] m;
    wr(ADDR_EXT0_CFG, 8'h02);
    wr(ADDR_IE, 8'h81);
    for (m = 8'h00; m < 8'h04; m++) begin
      wr(ADDR_TRIG, m);
      @(posedge clk_sys);
      port0Pins <= 7'h04;
      tick(8);
      chkF(irqReq, m != 8'h01);
      if (m == 8'h00) chk(irqVector, 16'h000b);
      wr(ADDR_TRIG, m);
      tick(8);
      chkF(irqReq, 1'h0);
      @(posedge clk_sys);
      port0Pins <= 7'h00;
      tick(8);
      chkF(irqReq, m != 8'h00);
      wr(ADDR_TRIG, m);
    end
    wr(ADDR_EXT0_CFG, 8'h0f);
    @(posedge clk_sys);
    port1Pins <= 8'h02;
    tick(8);
    chkF(irqReq, 1'h1);
    wr(ADDR_TRIG, 8'h00);
    wr(ADDR_EXT0_CFG, 8'h17);
    @(posedge clk_sys);
    cmp4Out <= 1'h1;
    tick(8);
    chkF(irqReq, 1'h1);
    wr(ADDR_TRIG, 8'h00);
    wr(ADDR_IE, 8'h00);
  endtask

  task automatic t_ext1();
    wr(ADDR_P1_FLAG, 8'h00);
    wr(ADDR_P2_FLAG, 8'h00);
    wr(ADDR_IE, 8'h84);
    wr(ADDR_P2_EN, 8'h80);
    wr(ADDR_TRIG, 8'h08);
    wr(ADDR_PRIO0, 8'h20);
    @(posedge clk_sys);
    port2Pins <= 8'h80;
    tick(8);
    chkF(irqReq, 1'h0);
    @(posedge clk_sys);
    port2Pins <= 8'h00;
    tick(8);
    chkF(irqReq, 1'h1);
    chk(irqVector, 16'h0013);
    chk(16'(irqLevel), 16'h0002);
    rd(ADDR_P2_FLAG);
    chk(rdVal, 16'h0080);
    wr(ADDR_P2_FLAG, 8'h00);
    chkF(irqReq, 1'h0);
    wr(ADDR_P1_EN, 8'h08);
    wr(ADDR_TRIG, 8'h10);
    @(posedge clk_sys);
    port1Pins <= 8'h0a;
    tick(8);
    chkF(irqReq, 1'h1);
    rd(ADDR_P1_FLAG);
    chk(rdVal, 16'h0008);
    wr(ADDR_P1_FLAG, 8'h00);
    @(posedge clk_sys);
    port1Pins <= 8'h02;
    tick(8);
    chkF(irqReq, 1'h1);
  endtask

  // Pins P1.1 and the comparator stay high through this reset, so a
  // false edge on P1.1 would show up in the pin flags.
  task automatic t_reset();
    wr(ADDR_PRIO0, 8'h55);
    @(posedge clk_sys);
    rstn <= 1'h0;
    tick(2);
    chkF(irqReq, 1'h0);
    chk(16'(activeLevels), 16'h0000);
    @(posedge clk_sys);
    rstn <= 1'h1;
    tick(3);
    rd(ADDR_PRIO0);
    chk(rdVal, 16'h0000);
    tick(8);
    rd(ADDR_P1_FLAG);
    chk(rdVal, 16'h0000);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'h1;
    tick(3);
    t_regs();
    t_thermal();
    t_arb();
    t_ext0();
    t_ext1();
    t_reset();
    wrap_up();
  end
endmodule
